// >>> csr_map.svh
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH
`define CSR_ADDR_STACK_PTR 8'h81
`define CSR_ADDR_PTR_LOW 8'h82
`define CSR_ADDR_PTR_HIGH 8'h83
`define CSR_ADDR_STATUS 8'hD0
`define CSR_ADDR_ACCUM 8'hE0
`define CSR_STACK_PTR_RESET 8'h07
`define CSR_STATUS_RESET 8'h00
`define CSR_ACCUM_RESET 8'h00
`define CSR_PTR_LOW_RESET 8'h00
`define CSR_PTR_HIGH_RESET 8'h00
`define CSR_BIT_CARRY 7
`define CSR_BIT_AUX 6
`define CSR_BIT_UF0 5
`define CSR_BIT_BSH 4
`define CSR_BIT_BSL 3
`define CSR_BIT_OVF 2
`define CSR_BIT_UF1 1
`define CSR_BIT_PAR 0
`define CSR_PRODUCT_LIMIT 16'h00FF
`endif

// >>> csr_pkg.sv
package csr_pkg;
  typedef enum logic [2:0] {
    CSR_FLAG_NONE = 3'h0,
    CSR_FLAG_ADD = 3'h1,
    CSR_FLAG_SUB = 3'h2,
    CSR_FLAG_MULT = 3'h3,
    CSR_FLAG_DIV = 3'h4,
    CSR_FLAG_OTHER = 3'h5
  } csr_flag_op_t;
  typedef enum logic [3:0] {
    CSR_ST_IDLE = 4'h1,
    CSR_ST_PUSH = 4'h2,
    CSR_ST_POP = 4'h4,
    CSR_ST_HOLD = 4'h8
  } csr_stk_state_t;
endpackage

// >>> csr_parity.sv
`timescale 1ns/10ps
module csr_parity #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] value,
  output logic odd
);
  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("WIDTH must be at least 1");
    end
  endgenerate
  logic [WIDTH:0] chain;
  assign chain[0] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      assign chain[i+1] = chain[i] ^ value[i];
    end
  endgenerate
  assign odd = chain[WIDTH];
endmodule

// >>> csr_core_regs.sv
`timescale 1ns/10ps
`include "csr_map.svh"
// Overview of operation
// - Push increments stack pointer first, then writes byte at the new address.
// - Reset loads stack pointer with seven; first push lands at eight.
// - Data pointer low and high bytes form one 16-bit flash pointer.
// - Carry set on add carry or subtract borrow, else cleared by arithmetic.
// - Auxiliary carry set on nibble carry or borrow, else cleared by arithmetic.
// - Status bits five and one are software flags, untouched by instructions.
// - Two-bit bank field selects one of four eight-register groups.
// - Overflow on signed add or subtract overflow, product above 255, or divide by zero.
// - Status bit zero continuously shows accumulator odd parity; read-only.
// - Undefined register addresses are reserved; reads give zero, writes ignored.
// - Stack pointer addresses the last used location; push goes to pointer plus one.
module csr_core_regs #(
  parameter int DATA_W = 8
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdHit,
  input wire logic bitWrEn,
  input wire logic [7:0] bitAddr,
  input wire logic bitWrVal,
  input wire logic accumWrEn,
  input wire logic [7:0] accumWrData,
  input wire logic dataPtrWrEn,
  input wire logic [15:0] dataPtrWrData,
  input wire logic pushReq,
  input wire logic popReq,
  input wire logic [7:0] pushData,
  output logic stkWrEn,
  output logic [7:0] stkAddr,
  output logic [7:0] stkWrData,
  input wire logic flagUpdEn,
  input wire csr_pkg::csr_flag_op_t flagOp,
  input wire logic [7:0] opA,
  input wire logic [7:0] opB,
  input wire logic carryIn,
  input wire logic [15:0] mulProduct,
  output logic [7:0] accumulator,
  output logic [7:0] stackPointer,
  output logic [15:0] dataPointer,
  output logic carryFlag,
  output logic [4:0] bankBase,
  output logic parityFlag
);
  import csr_pkg::*;

  generate
    if (DATA_W != 8)
    begin : g_bad_width
      $error("DATA_W must be 8");
    end
  endgenerate

  logic [7:0] accum_r, accum_nxt;
  logic [7:0] stkPtr_r, stkPtr_nxt;
  logic [7:0] ptrLow_r, ptrLow_nxt;
  logic [7:0] ptrHigh_r, ptrHigh_nxt;
  logic [7:0] status_r, status_nxt;
  logic stkWe_r, stkWe_nxt;
  logic [7:0] stkAddr_r, stkAddr_nxt;
  logic [7:0] stkData_r, stkData_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic hit_r, hit_nxt;
  csr_stk_state_t st_r, st_nxt;
  logic parity;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [8:0] diff9;
  logic [4:0] diff5;
  logic addrKnown;

  csr_parity #(
    .WIDTH(DATA_W)
  ) csr_parity_i (
    .value(accum_r),
    .odd(parity)
  );

  // Bit-addressable space maps each byte at multiples of eight
  always_comb
  begin
    case (regAddr)
      `CSR_ADDR_STACK_PTR, `CSR_ADDR_PTR_LOW, `CSR_ADDR_PTR_HIGH, `CSR_ADDR_STATUS,
      `CSR_ADDR_ACCUM:
        addrKnown = 1'b1;
      default:
        addrKnown = 1'b0;
    endcase
  end

  always_comb
  begin
    sum9 = {1'b0, opA} + {1'b0, opB} + {8'h00, carryIn};
    sum5 = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
    diff9 = {1'b0, opA} - {1'b0, opB} - {8'h00, carryIn};
    diff5 = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, carryIn};
  end

  always_comb
  begin
    accum_nxt = accum_r;
    ptrLow_nxt = ptrLow_r;
    ptrHigh_nxt = ptrHigh_r;
    status_nxt = status_r;
    if (accumWrEn)
      accum_nxt = accumWrData;
    if (dataPtrWrEn)
    begin
      ptrLow_nxt = dataPtrWrData[7:0];
      ptrHigh_nxt = dataPtrWrData[15:8];
    end
    // Arithmetic flags never touch the user flags or bank field
    if (flagUpdEn)
    begin
      case (flagOp)
        CSR_FLAG_ADD:
        begin
          status_nxt[`CSR_BIT_CARRY] = sum9[8];
          status_nxt[`CSR_BIT_AUX] = sum5[4];
          status_nxt[`CSR_BIT_OVF] = (opA[7] == opB[7]) && (sum9[7] != opA[7]);
        end
        CSR_FLAG_SUB:
        begin
          status_nxt[`CSR_BIT_CARRY] = diff9[8];
          status_nxt[`CSR_BIT_AUX] = diff5[4];
          status_nxt[`CSR_BIT_OVF] = (opA[7] != opB[7]) && (diff9[7] != opA[7]);
        end
        // No nibble carry here, so aux is cleared like carry
        CSR_FLAG_MULT:
        begin
          status_nxt[`CSR_BIT_CARRY] = 1'b0;
          status_nxt[`CSR_BIT_AUX] = 1'b0;
          status_nxt[`CSR_BIT_OVF] = mulProduct > `CSR_PRODUCT_LIMIT;
        end
        CSR_FLAG_DIV:
        begin
          status_nxt[`CSR_BIT_CARRY] = 1'b0;
          status_nxt[`CSR_BIT_AUX] = 1'b0;
          status_nxt[`CSR_BIT_OVF] = (opB == 8'h00);
        end
        CSR_FLAG_OTHER:
        begin
          status_nxt[`CSR_BIT_CARRY] = 1'b0;
          status_nxt[`CSR_BIT_AUX] = 1'b0;
        end
        default:
          status_nxt = status_nxt;
      endcase
    end
    // Software access wins over the core in the same cycle
    if (regWrEn)
    begin
      case (regAddr)
        `CSR_ADDR_ACCUM:
          accum_nxt = regWrData;
        `CSR_ADDR_PTR_LOW:
          ptrLow_nxt = regWrData;
        `CSR_ADDR_PTR_HIGH:
          ptrHigh_nxt = regWrData;
        `CSR_ADDR_STATUS:
          status_nxt[7:1] = regWrData[7:1];
        default:
          status_nxt = status_nxt;
      endcase
    end
    if (bitWrEn)
    begin
      if ({bitAddr[7:3], 3'h0} == `CSR_ADDR_STATUS && bitAddr[2:0] != 3'h0)
        status_nxt[bitAddr[2:0]] = bitWrVal;
      else if ({bitAddr[7:3], 3'h0} == `CSR_ADDR_ACCUM)
        accum_nxt[bitAddr[2:0]] = bitWrVal;
    end
    // Parity is derived, never stored from software
    status_nxt[`CSR_BIT_PAR] = 1'b0;
  end

  // Stack sequencing: increment, then write at the new pointer
  always_comb
  begin
    stkPtr_nxt = stkPtr_r;
    st_nxt = st_r;
    stkWe_nxt = 1'b0;
    stkAddr_nxt = stkAddr_r;
    stkData_nxt = stkData_r;
    case (st_r)
      CSR_ST_IDLE:
      begin
        if (pushReq)
        begin
          stkPtr_nxt = stkPtr_r + 8'h01;
          stkWe_nxt = 1'b1;
          stkAddr_nxt = stkPtr_r + 8'h01;
          stkData_nxt = pushData;
          st_nxt = CSR_ST_PUSH;
        end
        else if (popReq)
        begin
          stkAddr_nxt = stkPtr_r;
          stkPtr_nxt = stkPtr_r - 8'h01;
          st_nxt = CSR_ST_POP;
        end
      end
      CSR_ST_PUSH, CSR_ST_POP:
        st_nxt = CSR_ST_IDLE;
      default:
        st_nxt = CSR_ST_IDLE;
    endcase
    if (regWrEn && regAddr == `CSR_ADDR_STACK_PTR)
      stkPtr_nxt = regWrData;
  end

  always_comb
  begin
    rd_nxt = rd_r;
    hit_nxt = 1'b0;
    if (regRdEn)
    begin
      hit_nxt = addrKnown;
      case (regAddr)
        `CSR_ADDR_ACCUM:
          rd_nxt = accum_r;
        `CSR_ADDR_STACK_PTR:
          rd_nxt = stkPtr_r;
        `CSR_ADDR_PTR_LOW:
          rd_nxt = ptrLow_r;
        `CSR_ADDR_PTR_HIGH:
          rd_nxt = ptrHigh_r;
        `CSR_ADDR_STATUS:
          rd_nxt = {status_r[7:1], parity};
        default:
          rd_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      accum_r <= `CSR_ACCUM_RESET;
      stkPtr_r <= `CSR_STACK_PTR_RESET;
      ptrLow_r <= `CSR_PTR_LOW_RESET;
      ptrHigh_r <= `CSR_PTR_HIGH_RESET;
      status_r <= `CSR_STATUS_RESET;
      stkWe_r <= 1'b0;
      stkAddr_r <= 8'h00;
      stkData_r <= 8'h00;
      rd_r <= 8'h00;
      hit_r <= 1'b0;
      st_r <= CSR_ST_IDLE;
    end
    else if (clkEn)
    begin
      accum_r <= accum_nxt;
      stkPtr_r <= stkPtr_nxt;
      ptrLow_r <= ptrLow_nxt;
      ptrHigh_r <= ptrHigh_nxt;
      status_r <= status_nxt;
      stkWe_r <= stkWe_nxt;
      stkAddr_r <= stkAddr_nxt;
      stkData_r <= stkData_nxt;
      rd_r <= rd_nxt;
      hit_r <= hit_nxt;
      st_r <= st_nxt;
    end
  end

  assign regRdData = rd_r;
  assign regRdHit = hit_r;
  assign stkWrEn = stkWe_r;
  assign stkAddr = stkAddr_r;
  assign stkWrData = stkData_r;
  assign accumulator = accum_r;
  assign stackPointer = stkPtr_r;
  assign dataPointer = {ptrHigh_r, ptrLow_r};
  assign carryFlag = status_r[`CSR_BIT_CARRY];
  // Bank base is bank number times eight
  assign bankBase = {status_r[`CSR_BIT_BSH], status_r[`CSR_BIT_BSL], 3'h0};
  assign parityFlag = parity;
endmodule

// >>> csr_core_regs_chk.sv
`timescale 1ns/10ps
module csr_core_regs_chk (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regRdData,
  input wire logic regRdHit,
  input wire logic pushReq,
  input wire logic popReq,
  input wire logic [7:0] pushData,
  input wire logic stkWrEn,
  input wire logic [7:0] stkAddr,
  input wire logic [7:0] stkWrData,
  input wire logic [7:0] accumulator,
  input wire logic [7:0] stackPointer,
  input wire logic parityFlag
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // Busy cycle after a stack op is skipped, not judged
  sequence pushTake;
    clkEn && pushReq && !$past(pushReq || popReq);
  endsequence
  sequence popTake;
    clkEn && popReq && !pushReq && !$past(pushReq || popReq);
  endsequence
  push_incr_a: assert property (
    pushTake |=> stackPointer == $past(stackPointer) + 8'h01 && stkWrEn
      && stkAddr == stackPointer && stkWrData == $past(pushData)) else $error("bad push");
  pop_addr_a: assert property (
    popTake |=> stkAddr == $past(stackPointer) && !stkWrEn
      && stackPointer == $past(stackPointer) - 8'h01) else $error("bad pop");
  stk_pulse_a: assert property (
    stkWrEn |=> !stkWrEn) else $error("long write");
  sp_reset_a: assert property (
    $rose(nrst) |-> stackPointer == 8'h07) else $error("bad pointer reset");
  parity_live_a: assert property (
    parityFlag == ^accumulator) else $error("bad parity");
  acc_read_a: assert property (
    clkEn && regRdEn && regAddr == 8'hE0 |=> regRdHit && regRdData == $past(accumulator))
    else $error("bad read");
  rsvd_read_a: assert property (
    clkEn && regRdEn && !(regAddr inside {8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0})
      |=> !regRdHit && regRdData == 8'h00) else $error("reserved hit");
  psw_par_a: assert property (
    clkEn && regRdEn && regAddr == 8'hD0 |=> regRdData[0] == $past(parityFlag))
    else $error("bad status parity");
endmodule
bind csr_core_regs csr_core_regs_chk csr_core_regs_chk_i (.sys_clk, .nrst, .clkEn,
  .regRdEn, .regAddr, .regRdData, .regRdHit, .pushReq, .popReq, .pushData, .stkWrEn,
  .stkAddr, .stkWrData, .accumulator, .stackPointer, .parityFlag);

// >>> test_csr_core_regs.sv
`timescale 1ns/10ps
module test_csr_core_regs;
  import csr_pkg::*;
  logic sys_clk = '0, nrst = '0, clkEn = '1, regWrEn = '0, regRdEn = '0, bitWrEn = '0;
  logic bitWrVal = '0, accumWrEn = '0, dataPtrWrEn = '0, pushReq = '0, popReq = '0;
  logic flagUpdEn = '0, carryIn = '0, stkWrEn, regRdHit, carryFlag, parityFlag;
  logic [7:0] regAddr = '0, regWrData = '0, bitAddr = '0, accumWrData = '0, pushData = '0;
  logic [7:0] opA = '0, opB = '0, regRdData, stkAddr, stkWrData, accumulator, stackPointer;
  logic [15:0] dataPtrWrData = '0, mulProduct = '0, dataPointer;
  logic [4:0] bankBase;
  logic [7:0] rsv [6] = '{8'h97, 8'hAE, 8'hB4, 8'hD2, 8'hDF, 8'hF5};
  csr_flag_op_t flagOp = CSR_FLAG_NONE;
  int n_errors = 0;
  int check_count = 0;
  csr_core_regs csr_core_regs_i (.sys_clk, .nrst, .clkEn, .regWrEn, .regRdEn, .regAddr,
    .regWrData, .regRdData, .regRdHit, .bitWrEn, .bitAddr, .bitWrVal, .accumWrEn,
    .accumWrData, .dataPtrWrEn, .dataPtrWrData, .pushReq, .popReq, .pushData, .stkWrEn,
    .stkAddr, .stkWrData,
    .flagUpdEn, .flagOp, .opA, .opB, .carryIn, .mulProduct, .accumulator, .stackPointer,
    .dataPointer, .carryFlag, .bankBase, .parityFlag);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  // Leading idle edge keeps each strobe assigned once per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    regWrEn = '1;
    regAddr = a;
    regWrData = d;
    tick();
    regWrEn = '0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    tick();
    regRdEn = '1;
    regAddr = a;
    tick();
    regRdEn = '0;
    chk(regRdData, e);
    chk(regRdHit, a inside {8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0});
  endtask
  task automatic fl(input csr_flag_op_t op, input logic [7:0] a, input logic [7:0] b,
    input logic [15:0] p, input logic [7:0] e);
    tick();
    flagUpdEn = '1;
    flagOp = op;
    opA = a;
    opB = b;
    mulProduct = p;
    tick();
    flagUpdEn = '0;
    rc(8'hD0, e);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end
  initial
  begin
    #20000;
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (2) @(posedge sys_clk);
    #1;
    nrst = '1;
    rc(8'h81, 8'h07);
    rc(8'hD0, 8'h00);
    rc(8'h83, 8'h00);
    fl(CSR_FLAG_ADD, 8'hFF, 8'h01, 16'h0000, 8'hC0);
    chk(carryFlag, 16'h0001);
    fl(CSR_FLAG_ADD, 8'h7F, 8'h01, 16'h0000, 8'h44);
    fl(CSR_FLAG_SUB, 8'h00, 8'h01, 16'h0000, 8'hC0);
    fl(CSR_FLAG_SUB, 8'h80, 8'h01, 16'h0000, 8'h44);
    fl(CSR_FLAG_MULT, 8'h10, 8'h10, 16'h0100, 8'h04);
    fl(CSR_FLAG_MULT, 8'h0F, 8'h11, 16'h00FF, 8'h00);
    fl(CSR_FLAG_DIV, 8'h05, 8'h00, 16'h0000, 8'h04);
    fl(CSR_FLAG_DIV, 8'h05, 8'h01, 16'h0000, 8'h00);
    fl(CSR_FLAG_OTHER, 8'h00, 8'h00, 16'h0000, 8'h00);
    // Carry-in alone pushes the low nibble over
    carryIn = '1;
    fl(CSR_FLAG_ADD, 8'h0F, 8'h00, 16'h0000, 8'h40);
    carryIn = '0;
    for (int b = 0; b < 4; b++)
    begin
      wr(8'hD0, 8'h23 | 8'(b << 3));
      rc(8'hD0, 8'h22 | 8'(b << 3));
      chk(bankBase, 16'(b * 8));
    end
    fl(CSR_FLAG_ADD, 8'h00, 8'h00, 16'h0000, 8'h3A);
    tick();
    bitWrEn = '1;
    bitAddr = 8'hD5;
    tick();
    bitWrEn = '0;
    rc(8'hD0, 8'h1A);
    tick();
    accumWrEn = '1;
    accumWrData = 8'h07;
    tick();
    accumWrEn = '0;
    chk(parityFlag, 16'h0001);
    rc(8'hD0, 8'h1B);
    wr(8'hE0, 8'h03);
    chk(parityFlag, 16'h0000);
    tick();
    pushReq = '1;
    pushData = 8'hA5;
    tick();
    chk(stkAddr, 16'h0008);
    chk(stkWrData, 16'h00A5);
    pushData = 8'h3C;
    tick();
    chk(stkWrEn, 16'h0000);
    pushReq = '0;
    rc(8'h81, 8'h08);
    tick();
    popReq = '1;
    tick();
    popReq = '0;
    chk(stkAddr, 16'h0008);
    rc(8'h81, 8'h07);
    wr(8'h82, 8'h34);
    wr(8'h83, 8'h12);
    chk(dataPointer, 16'h1234);
    foreach (rsv[i])
    begin
      wr(rsv[i], 8'hFF);
      rc(rsv[i], 8'h00);
    end
    // A frozen edge must not take the core write
    tick();
    clkEn = '0;
    accumWrEn = '1;
    accumWrData = 8'hFF;
    tick();
    accumWrEn = '0;
    clkEn = '1;
    rc(8'hE0, 8'h03);
    report_and_stop();
  end
endmodule
